//--- logic/rxsts_regs.sv
// dual receive-port status register bank read over the local register port
`default_nettype none
module rxsts_regs #(
	parameter int NPORTS = 2
) (
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	// register port: one-cycle strobes, read data registered
	input  wire logic [7:0]  i_addr,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	// receiver status, per port bit 0 and bit 1 (pins, synchronised here)
	input  wire logic [1:0]  i_lock,
	input  wire logic [1:0]  i_pass,
	input  wire logic [1:0]  i_parity_over,
	input  wire logic [1:0]  i_csi_err,
	input  wire logic [1:0]  i_cable_fault,
	input  wire logic [1:0]  i_freq_measure_stable,
	// one-cycle event pulses from same-clock receiver logic
	input  wire logic [1:0]  i_crc_err_evt,
	input  wire logic [1:0]  i_seq_err_evt,
	input  wire logic [1:0]  i_len_unstable_evt,
	input  wire logic [1:0]  i_len_chg_evt,
	input  wire logic [1:0]  i_enc_err_evt,
	input  wire logic [1:0]  i_buf_ovf_evt,
	input  wire logic [1:0]  i_cnt_chg_evt,
	// measured frequency, same clock
	input  wire logic [15:0] i_freq0,
	input  wire logic [15:0] i_freq1,
	output logic             o_read_port
);
	initial
	begin
		if (NPORTS != 2)
			$error("rxsts_regs serves exactly two ports");
	end

	localparam int NLIVE = 6;

	logic [NLIVE*2-1:0] live_meta_reg;
	logic [NLIVE*2-1:0] live_sync_reg;
	logic               psel_reg;
	logic [7:0]         rdata_reg;
	logic [7:0]         rdata_next;

	// live levels come from outside the clock, two flops first
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			live_meta_reg <= '0;
			live_sync_reg <= '0;
		end
		else
		begin
			live_meta_reg <= {i_lock, i_pass, i_parity_over, i_csi_err, i_cable_fault, i_freq_measure_stable};
			live_sync_reg <= live_meta_reg;
		end
	end

	wire [1:0] lock_s   = live_sync_reg[11:10];
	wire [1:0] pass_s   = live_sync_reg[9:8];
	wire [1:0] par_s    = live_sync_reg[7:6];
	wire [1:0] csi_s    = live_sync_reg[5:4];
	wire [1:0] cable_s  = live_sync_reg[3:2];
	wire [1:0] stable_s = live_sync_reg[1:0];

	// decode
	wire rd_psel  = i_rd && (i_addr == rxsts_pkg::RXSTS_ADDR_PSEL);
	wire rd_sts1  = i_rd && (i_addr == rxsts_pkg::RXSTS_ADDR_STS1);
	wire rd_sts2  = i_rd && (i_addr == rxsts_pkg::RXSTS_ADDR_STS2);
	wire rd_fint  = i_rd && (i_addr == rxsts_pkg::RXSTS_ADDR_FINT);
	wire rd_ffrac = i_rd && (i_addr == rxsts_pkg::RXSTS_ADDR_FFRAC);
	wire rd_other = i_rd && !(rd_psel || rd_sts1 || rd_sts2 || rd_fint || rd_ffrac);
	wire wr_psel  = i_wr && (i_addr == rxsts_pkg::RXSTS_ADDR_PSEL);

	// port select; other select bits not modelled here
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			psel_reg <= 1'b0;
		else if (wr_psel)
			psel_reg <= i_wdata[rxsts_pkg::RXSTS_PSEL_BIT]; // see RL17
	end

	assign o_read_port = psel_reg;

	logic [7:0] flags [2];
	logic [7:0] evts  [2];

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++)
		begin : g_port
			logic sel_here;
			assign sel_here = (psel_reg == 1'(gp));
			assign evts[gp][rxsts_pkg::F_CRC]     = i_crc_err_evt[gp];      // see RL2
			assign evts[gp][rxsts_pkg::F_LOCKCHG] = 1'b0;
			assign evts[gp][rxsts_pkg::F_SEQ]     = i_seq_err_evt[gp];      // see RL4
			assign evts[gp][rxsts_pkg::F_LENUNST] = i_len_unstable_evt[gp]; // see RL8
			assign evts[gp][rxsts_pkg::F_LENCHG]  = i_len_chg_evt[gp];      // see RL9
			assign evts[gp][rxsts_pkg::F_ENC]     = i_enc_err_evt[gp];      // see RL10
			assign evts[gp][rxsts_pkg::F_BUF]     = i_buf_ovf_evt[gp];      // see RL12
			assign evts[gp][rxsts_pkg::F_CNTCHG]  = i_cnt_chg_evt[gp];      // see RL15
			// only the selected port's copy is cleared by a read
			rxsts_port u_port (
				.i_mclk     (i_mclk),
				.i_resetn   (i_resetn),
				.i_events   (evts[gp]),
				.i_lock     (lock_s[gp]),
				.i_clr_sts1 (rd_sts1 && sel_here),
				.i_clr_sts2 (rd_sts2 && sel_here),
				.o_flags    (flags[gp])
			);
		end
	endgenerate

	wire [7:0]  fl  = flags[psel_reg];
	wire [15:0] frq = psel_reg ? i_freq1 : i_freq0; // see RL17

	wire [7:0] sts1_val = {1'b0,
		psel_reg,                          // see RL1
		fl[rxsts_pkg::F_CRC],
		fl[rxsts_pkg::F_LOCKCHG],
		fl[rxsts_pkg::F_SEQ],
		par_s[psel_reg],                   // see RL5
		pass_s[psel_reg],                  // see RL6
		lock_s[psel_reg]};                 // see RL7

	wire [7:0] sts2_val = {fl[rxsts_pkg::F_LENUNST],
		fl[rxsts_pkg::F_LENCHG],
		fl[rxsts_pkg::F_ENC],              // relies on host error counting setup, see RL11
		fl[rxsts_pkg::F_BUF],
		csi_s[psel_reg],                   // see RL13
		stable_s[psel_reg],                // see RL16
		cable_s[psel_reg],                 // see RL14
		fl[rxsts_pkg::F_CNTCHG]};

	wire [7:0] psel_val = {3'b000, psel_reg, 4'h0};

	always_comb
	begin
		rdata_next = rdata_reg;
		if (rd_psel)
			rdata_next = psel_val;
		else if (rd_sts1)
			rdata_next = sts1_val;
		else if (rd_sts2)
			rdata_next = sts2_val;
		else if (rd_fint)
			rdata_next = frq[15:8];            // see RL16
		else if (rd_ffrac)
			rdata_next = frq[7:0];             // see RL18
		else if (i_rd)
			rdata_next = rxsts_pkg::RXSTS_UNMAPPED;
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			rdata_reg <= rxsts_pkg::RXSTS_RESET_VAL;
		else
			rdata_reg <= rdata_next;
	end

	assign o_rdata = rdata_reg;

	// assertions
	property p_port_num;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_sts1 |=> o_rdata[rxsts_pkg::S1_PORT_NUM] == $past(psel_reg);
	endproperty
	a_port_num: assert property (p_port_num) else $error("port number field wrong"); // see RL1

	property p_crc_clear;
		@(posedge i_mclk) disable iff (!i_resetn)
		(rd_sts1 && !psel_reg && !i_crc_err_evt[0]) |=> !flags[0][rxsts_pkg::F_CRC];
	endproperty
	a_crc_clear: assert property (p_crc_clear) else $error("crc flag not cleared on read"); // see RL2

	property p_crc_set;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_crc_err_evt[0] |=> flags[0][rxsts_pkg::F_CRC];
	endproperty
	a_crc_set: assert property (p_crc_set) else $error("crc event lost"); // see RL19

	property p_lock_chg;
		@(posedge i_mclk) disable iff (!i_resetn)
		($past(i_resetn) && (lock_s[0] != $past(lock_s[0]))) |=> flags[0][rxsts_pkg::F_LOCKCHG];
	endproperty
	a_lock_chg: assert property (p_lock_chg) else $error("lock change not flagged"); // see RL3

	property p_seq_set;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_seq_err_evt[1] |=> flags[1][rxsts_pkg::F_SEQ];
	endproperty
	a_seq_set: assert property (p_seq_set) else $error("sequence error lost"); // see RL4

	property p_lock_live;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_sts1 |=> o_rdata[rxsts_pkg::S1_LOCK] == $past(lock_s[psel_reg]);
	endproperty
	a_lock_live: assert property (p_lock_live) else $error("lock bit not live"); // see RL7

	property p_unstable_hold;
		@(posedge i_mclk) disable iff (!i_resetn)
		(flags[0][rxsts_pkg::F_LENUNST] && !(rd_sts2 && !psel_reg)) |=> flags[0][rxsts_pkg::F_LENUNST];
	endproperty
	a_unstable_hold: assert property (p_unstable_hold) else $error("unstable flag dropped early"); // see RL8

	property p_freq_int;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_fint |=> o_rdata == $past(frq[15:8]);
	endproperty
	a_freq_int: assert property (p_freq_int) else $error("frequency byte wrong"); // see RL16

	// request shapes reused below
	sequence s_p0_sts1_read_steady;
		rd_sts1 && !psel_reg && $past(i_resetn) && (lock_s[0] == $past(lock_s[0]));
	endsequence

	sequence s_p1_sts2_read_quiet;
		rd_sts2 && psel_reg && (evts[1][rxsts_pkg::F_CNTCHG:rxsts_pkg::F_LENUNST] == '0);
	endsequence

	property p_crc_clear_p1;
		@(posedge i_mclk) disable iff (!i_resetn)
		(rd_sts1 && psel_reg && !i_crc_err_evt[1]) |=> !flags[1][rxsts_pkg::F_CRC];
	endproperty
	a_crc_clear_p1: assert property (p_crc_clear_p1) else $error("port one crc flag not cleared"); // see RL2

	property p_crc_kept_in_read;
		@(posedge i_mclk) disable iff (!i_resetn)
		(rd_sts1 && psel_reg && i_crc_err_evt[1]) |=> flags[1][rxsts_pkg::F_CRC];
	endproperty
	a_crc_kept_in_read: assert property (p_crc_kept_in_read) else $error("crc event in read lost"); // see RL19

	property p_lock_chg_clear;
		@(posedge i_mclk) disable iff (!i_resetn)
		s_p0_sts1_read_steady |=> !flags[0][rxsts_pkg::F_LOCKCHG];
	endproperty
	a_lock_chg_clear: assert property (p_lock_chg_clear) else $error("lock change not cleared"); // see RL3

	property p_seq_clear;
		@(posedge i_mclk) disable iff (!i_resetn)
		(rd_sts1 && !psel_reg && !i_seq_err_evt[0]) |=> !flags[0][rxsts_pkg::F_SEQ];
	endproperty
	a_seq_clear: assert property (p_seq_clear) else $error("sequence flag not cleared"); // see RL4

	property p_parity_live;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_sts1 |=> o_rdata[rxsts_pkg::S1_PARITY] == $past(par_s[psel_reg]);
	endproperty
	a_parity_live: assert property (p_parity_live) else $error("parity bit not live"); // see RL5

	property p_pass_live;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_sts1 |=> o_rdata[rxsts_pkg::S1_PASS] == $past(pass_s[psel_reg]);
	endproperty
	a_pass_live: assert property (p_pass_live) else $error("pass bit not live"); // see RL6

	property p_reserved_zero;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_sts1 |=> !o_rdata[rxsts_pkg::RXSTS_DATA_W-1];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // see RL1

	property p_unstable_set;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_len_unstable_evt[1] |=> flags[1][rxsts_pkg::F_LENUNST];
	endproperty
	a_unstable_set: assert property (p_unstable_set) else $error("unstable event lost"); // see RL8

	property p_unstable_clear;
		@(posedge i_mclk) disable iff (!i_resetn)
		(rd_sts2 && !psel_reg && !i_len_unstable_evt[0]) |=> !flags[0][rxsts_pkg::F_LENUNST];
	endproperty
	a_unstable_clear: assert property (p_unstable_clear) else $error("unstable flag not cleared"); // see RL8

	property p_lenchg_set;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_len_chg_evt[0] |=> flags[0][rxsts_pkg::F_LENCHG];
	endproperty
	a_lenchg_set: assert property (p_lenchg_set) else $error("line length change lost"); // see RL9

	property p_enc_set;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_enc_err_evt[1] |=> flags[1][rxsts_pkg::F_ENC];
	endproperty
	a_enc_set: assert property (p_enc_set) else $error("encoder error lost"); // see RL10

	property p_buf_set;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_buf_ovf_evt[0] |=> flags[0][rxsts_pkg::F_BUF];
	endproperty
	a_buf_set: assert property (p_buf_set) else $error("buffer overflow lost"); // see RL12

	property p_sts2_clear;
		@(posedge i_mclk) disable iff (!i_resetn)
		s_p1_sts2_read_quiet |=> flags[1][rxsts_pkg::F_CNTCHG:rxsts_pkg::F_LENUNST] == '0;
	endproperty
	a_sts2_clear: assert property (p_sts2_clear) else $error("status two flags not cleared"); // see RL12

	property p_csi_live;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_sts2 |=> o_rdata[rxsts_pkg::S2_CSI_ERR] == $past(csi_s[psel_reg]);
	endproperty
	a_csi_live: assert property (p_csi_live) else $error("csi summary not live"); // see RL13

	property p_cable_live;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_sts2 |=> o_rdata[rxsts_pkg::S2_CABLE_FAULT] == $past(cable_s[psel_reg]);
	endproperty
	a_cable_live: assert property (p_cable_live) else $error("cable fault not live"); // see RL14

	property p_cnt_set;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_cnt_chg_evt[1] |=> flags[1][rxsts_pkg::F_CNTCHG];
	endproperty
	a_cnt_set: assert property (p_cnt_set) else $error("line count change lost"); // see RL15

	property p_stable_live;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_sts2 |=> o_rdata[rxsts_pkg::S2_FREQ_MEASURE_STABLE] == $past(stable_s[psel_reg]);
	endproperty
	a_stable_live: assert property (p_stable_live) else $error("stable flag not live"); // see RL16

	property p_freq_frac;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_ffrac |=> o_rdata == $past(frq[7:0]);
	endproperty
	a_freq_frac: assert property (p_freq_frac) else $error("fraction byte wrong"); // see RL18

	property p_psel_write;
		@(posedge i_mclk) disable iff (!i_resetn)
		wr_psel |=> psel_reg == $past(i_wdata[rxsts_pkg::RXSTS_PSEL_BIT]);
	endproperty
	a_psel_write: assert property (p_psel_write) else $error("port select not written"); // see RL17

	property p_other_port_kept;
		@(posedge i_mclk) disable iff (!i_resetn)
		(rd_sts1 && !psel_reg && flags[1][rxsts_pkg::F_CRC]) |=> flags[1][rxsts_pkg::F_CRC];
	endproperty
	a_other_port_kept: assert property (p_other_port_kept) else $error("unselected port cleared"); // see RL17

	property p_unmapped;
		@(posedge i_mclk) disable iff (!i_resetn)
		rd_other |=> o_rdata == rxsts_pkg::RXSTS_UNMAPPED;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // see RL17

	property p_rdata_holds;
		@(posedge i_mclk) disable iff (!i_resetn)
		($past(i_resetn) && !i_rd) |=> o_rdata == $past(o_rdata);
	endproperty
	a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without read"); // see RL17
endmodule
`default_nettype wire

//--- logic/rxsts_pkg.sv
// register map, field positions and reset values of the receive-port status bank
//
// How it works
// RL1 - status one bit 6 shows selected read port
// RL2 - control channel crc error, clear on read
// RL3 - lock changed since last read, clear on read
// RL4 - control channel sequence error, clear on read
// RL5 - parity flag while count exceeds threshold
// RL6 - pass bit shows live pass indication
// RL7 - lock bit shows live receiver lock
// RL8 - line length unstable sticky until read
// RL9 - line length changed, clear on read
// RL10 - link encoder error, clear on read
// RL11 - host enables error counting, threshold above one
// RL12 - buffer overflow error, clear on read
// RL13 - csi error summarises csi detail status
// RL14 - cable fault when no link clock
// RL15 - line count changed, clear on read
// RL16 - integer mhz byte plus stable flag
// RL17 - port select bit chooses readback port
// RL18 - fractional frequency byte at next offset
// RL19 - event during clearing read is kept
`default_nettype none
package rxsts_pkg;
	localparam int          RXSTS_ADDR_W     = 8;
	localparam int          RXSTS_DATA_W     = 8;
	localparam logic [7:0]  RXSTS_ADDR_PSEL  = 8'h4c;
	localparam logic [7:0]  RXSTS_ADDR_STS1  = 8'h4d;
	localparam logic [7:0]  RXSTS_ADDR_STS2  = 8'h4e;
	localparam logic [7:0]  RXSTS_ADDR_FINT  = 8'h4f;
	localparam logic [7:0]  RXSTS_ADDR_FFRAC = 8'h50;
	localparam int          RXSTS_PSEL_BIT   = 4;
	// status one fields
	localparam int          S1_PORT_NUM      = 6;
	localparam int          S1_CRC_ERR       = 5;
	localparam int          S1_LOCK_CHG      = 4;
	localparam int          S1_SEQ_ERR       = 3;
	localparam int          S1_PARITY        = 2;
	localparam int          S1_PASS          = 1;
	localparam int          S1_LOCK          = 0;
	// status two fields
	localparam int          S2_LEN_UNSTABLE  = 7;
	localparam int          S2_LEN_CHG       = 6;
	localparam int          S2_ENC_ERR       = 5;
	localparam int          S2_BUF_ERR       = 4;
	localparam int          S2_CSI_ERR       = 3;
	localparam int          S2_FREQ_MEASURE_STABLE   = 2;
	localparam int          S2_CABLE_FAULT   = 1;
	localparam int          S2_LINE_COUNT_CHANGED  = 0;
	localparam logic [7:0]  RXSTS_RESET_VAL  = 8'h00;
	localparam logic [7:0]  RXSTS_UNMAPPED   = 8'h00;
	// sticky flags per port, in this order
	localparam int          RXSTS_NFLAGS     = 8;
	localparam int          F_CRC            = 0;
	localparam int          F_LOCKCHG        = 1;
	localparam int          F_SEQ            = 2;
	localparam int          F_LENUNST        = 3;
	localparam int          F_LENCHG         = 4;
	localparam int          F_ENC            = 5;
	localparam int          F_BUF            = 6;
	localparam int          F_CNTCHG         = 7;
endpackage
`default_nettype wire

//--- logic/rxsts_port.sv
// per-port status copy: sticky clear-on-read flags and lock history
`default_nettype none
module rxsts_port (
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_events,
	input  wire logic        i_lock,
	input  wire logic        i_clr_sts1,
	input  wire logic        i_clr_sts2,
	output logic      [7:0]  o_flags
);
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] clr_mask;
	logic       lock_at_read_reg;
	logic       lock_prev_reg;
	logic       lock_ref;
	logic       lock_diff;

	// a read re-bases on last cycle's lock, which the returned bit already covers,
	// so a change landing in the read cycle itself stays flagged   // see RL19
	assign lock_ref  = i_clr_sts1 ? lock_prev_reg : lock_at_read_reg;
	assign lock_diff = i_lock ^ lock_ref;

	assign clr_mask[rxsts_pkg::F_CRC]     = i_clr_sts1;
	assign clr_mask[rxsts_pkg::F_LOCKCHG] = i_clr_sts1;
	assign clr_mask[rxsts_pkg::F_SEQ]     = i_clr_sts1;
	assign clr_mask[rxsts_pkg::F_LENUNST] = i_clr_sts2;
	assign clr_mask[rxsts_pkg::F_LENCHG]  = i_clr_sts2;
	assign clr_mask[rxsts_pkg::F_ENC]     = i_clr_sts2;
	assign clr_mask[rxsts_pkg::F_BUF]     = i_clr_sts2;
	assign clr_mask[rxsts_pkg::F_CNTCHG]  = i_clr_sts2;

	// set beats clear so an event in the read cycle shows next read   // see RL19
	always_comb
	begin
		flags_next = (flags_reg & ~clr_mask) | i_events;
		flags_next[rxsts_pkg::F_LOCKCHG] = lock_diff | (flags_reg[rxsts_pkg::F_LOCKCHG] & ~i_clr_sts1); // see RL3
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			flags_reg        <= rxsts_pkg::RXSTS_RESET_VAL;
			lock_at_read_reg <= 1'b0;
			lock_prev_reg    <= 1'b0;
		end
		else
		begin
			flags_reg        <= flags_next;
			lock_prev_reg    <= i_lock;
			lock_at_read_reg <= lock_ref; // see RL3
		end
	end

	assign o_flags = flags_reg;
endmodule
`default_nettype wire

//--- dv/rxsts_rx_model.sv
// far-side receiver model: one-cycle event pulses for a chosen port and kind
`default_nettype none
module rxsts_rx_model (
	input  wire logic       i_go,
	input  wire logic [2:0] i_kind,
	input  wire logic       i_port,
	output logic      [1:0] o_crc,
	output logic      [1:0] o_seq,
	output logic      [1:0] o_lenu,
	output logic      [1:0] o_lenc,
	output logic      [1:0] o_enc,
	output logic      [1:0] o_buf,
	output logic      [1:0] o_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [1:0] hit;
	// the bench holds i_go one cycle, so every pulse is exactly one cycle wide
	assign hit = i_go ? (2'h1 << i_port) : 2'h0;
	assign o_crc = (i_kind == 3'h0) ? hit : 2'h0;
	assign o_seq = (i_kind == 3'h1) ? hit : 2'h0;
	assign o_lenu = (i_kind == 3'h2) ? hit : 2'h0;
	assign o_lenc = (i_kind == 3'h3) ? hit : 2'h0;
	assign o_enc = (i_kind == 3'h4) ? hit : 2'h0; // encoder error pulse, not gated by lock; the bench fires it on port 1 while its lock is low
	assign o_buf = (i_kind == 3'h5) ? hit : 2'h0;
	assign o_cnt = (i_kind == 3'h6) ? hit : 2'h0;
endmodule
`default_nettype wire

//--- dv/rxsts_regs_bench.sv
// self-checking bench for the receive-port status bank
`default_nettype none
module rxsts_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_mclk = 1'b0;
	logic        i_resetn = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic        i_rd = 1'b0;
	logic        i_wr = 1'b0;
	logic [7:0]  i_wdata = 8'h00;
	logic [1:0]  i_lock = 2'h0, i_pass = 2'h0, i_par = 2'h0, i_csi = 2'h0, i_cab = 2'h0, i_fst = 2'h0;
	logic [15:0] i_freq0 = 16'h0000, i_freq1 = 16'h0000;
	logic        go = 1'b0;
	logic        port = 1'b0;
	logic [2:0]  kind = 3'h0;
	logic [7:0]  v;
	wire  [7:0]  o_rdata;
	wire         o_read_port;
	wire  [1:0]  e_crc, e_seq, e_lenu, e_lenc, e_enc, e_buf, e_cnt;
	int          errors = 0;
	int          comparisons = 0;
	logic [7:0]  ea [7] = '{8'h4d, 8'h4d, 8'h4e, 8'h4e, 8'h4e, 8'h4e, 8'h4e};
	logic [7:0]  eb [7] = '{8'h20, 8'h08, 8'h80, 8'h40, 8'h20, 8'h10, 8'h01};

	always #4 i_mclk = ~i_mclk;

	rxsts_rx_model u_rxsts_rx_model (.i_go(go), .i_kind(kind), .i_port(port), .o_crc(e_crc), .o_seq(e_seq),
		.o_lenu(e_lenu), .o_lenc(e_lenc), .o_enc(e_enc), .o_buf(e_buf), .o_cnt(e_cnt));

	rxsts_regs #(.NPORTS(2)) u_rxsts_regs (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd),
		.i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_lock(i_lock), .i_pass(i_pass),
		.i_parity_over(i_par), .i_csi_err(i_csi), .i_cable_fault(i_cab), .i_freq_measure_stable(i_fst),
		.i_crc_err_evt(e_crc), .i_seq_err_evt(e_seq), .i_len_unstable_evt(e_lenu), .i_len_chg_evt(e_lenc),
		.i_enc_err_evt(e_enc), .i_buf_ovf_evt(e_buf), .i_cnt_chg_evt(e_cnt), .i_freq0(i_freq0),
		.i_freq1(i_freq1), .o_read_port(o_read_port));

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		i_addr = a;
		i_wdata = d;
		i_wr = 1'b1;
		@(negedge i_mclk);
		i_wr = 1'b0;
	endtask

	// read data is registered at the strobe edge and settled by the next falling edge
	task automatic rd(input logic [7:0] a, input logic ev, output logic [7:0] d);
		@(negedge i_mclk);
		i_addr = a;
		i_rd = 1'b1;
		go = ev;
		@(negedge i_mclk);
		i_rd = 1'b0;
		go = 1'b0;
		d = o_rdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
		logic [7:0] d;
		rd(a, 1'b0, d);
		check(n, d, e);
	endtask

	task automatic fire(input logic [2:0] k, input logic p);
		@(negedge i_mclk);
		kind = k;
		port = p;
		go = 1'b1;
		@(negedge i_mclk);
		go = 1'b0;
	endtask

	task automatic test_done;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#100000;
		errors++;
		test_done();
	end

	initial
	begin
		repeat (8) @(negedge i_mclk);
		i_resetn = 1'b1;
		rc(8'h4d, 8'h00, "sts1 reset");
		rc(8'h4e, 8'h00, "sts2 reset");
		rc(8'h4f, 8'h00, "freq int reset");
		rc(8'h51, 8'h00, "unmapped");
		i_lock = 2'h1;
		i_pass = 2'h1;
		i_par = 2'h1;
		i_csi = 2'h1;
		i_cab = 2'h1;
		i_fst = 2'h1;
		i_freq0 = 16'h1234;
		i_freq1 = 16'habcd;
		// live levels pass a two-flop synchroniser
		repeat (3) @(negedge i_mclk);
		rc(8'h4d, 8'h17, "sts1 lock change");
		rc(8'h4d, 8'h07, "sts1 live");
		rc(8'h4e, 8'h0e, "sts2 live");
		wr(8'h4f, 8'hff);
		rc(8'h4f, 8'h12, "freq int p0");
		rc(8'h50, 8'h34, "freq frac p0");
		for (int k = 0; k < 7; k++)
		begin
			fire(k[2:0], 1'b1);
			fire(k[2:0], 1'b0);
			rc(ea[k], eb[k] | ((ea[k] == 8'h4d) ? 8'h07 : 8'h0e), "event set");
			rc(ea[k], (ea[k] == 8'h4d) ? 8'h07 : 8'h0e, "event cleared");
		end
		wr(8'h4c, 8'h10);
		check("read port", {7'h00, o_read_port}, 8'h01);
		rc(8'h4c, 8'h10, "port select");
		rc(8'h4d, 8'h68, "sts1 p1 flags");
		rc(8'h4e, 8'hf1, "sts2 p1 flags");
		rc(8'h4d, 8'h40, "sts1 p1 cleared");
		rc(8'h4e, 8'h00, "sts2 p1 cleared");
		rc(8'h4f, 8'hab, "freq int p1");
		rc(8'h50, 8'hcd, "freq frac p1");
		kind = 3'h0;
		port = 1'b1;
		rd(8'h4d, 1'b1, v);
		check("read during event", v, 8'h40);
		rc(8'h4d, 8'h60, "event during read kept");
		wr(8'h4c, 8'h00);
		i_lock = 2'h0;
		i_par = 2'h0;
		repeat (3) @(negedge i_mclk);
		rc(8'h4d, 8'h12, "lock lost");
		wr(8'h4c, 8'h10);
		@(negedge i_mclk);
		i_resetn = 1'b0;
		@(negedge i_mclk);
		check("reset read port", {7'h00, o_read_port}, 8'h00);
		check("reset rdata", o_rdata, 8'h00);
		i_resetn = 1'b1;
		repeat (3) @(negedge i_mclk);
		rc(8'h4d, 8'h02, "after reset");
		test_done();
	end
endmodule
`default_nettype wire
